// [common/ivp_regs.svh]
/*
 * Register offsets, field positions, reset values and vector numbers of
 * the interrupt vector placement block.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef IVP_REGS_SVH
`define IVP_REGS_SVH

// ==========================================================================
// Register byte offsets and decode codes
`define IVP_OFS_CONTROL     32'h0000_0000
`define IVP_OFS_EVT_STATUS  32'h0000_0004
`define IVP_OFS_EVT_MASK    32'h0000_0008
`define IVP_OFS_STATE       32'h0000_000C
`define IVP_OFS_WDT_FLAG    32'h0000_0010
`define IVP_SEL_CONTROL     3'h0
`define IVP_SEL_EVT_STATUS  3'h1
`define IVP_SEL_EVT_MASK    3'h2
`define IVP_SEL_STATE       3'h3
`define IVP_SEL_WDT_FLAG    3'h4
`define IVP_SEL_NONE        3'h7
`define IVP_RESP_OKAY       2'h0
`define IVP_RESP_SLVERR     2'h2

// ==========================================================================
// Control register fields and event bits
`define IVP_CTL_DEBUG_DIS   7
`define IVP_CTL_PULLUP_DIS  4
`define IVP_CTL_SELECT      1
`define IVP_CTL_UNLOCK      0
`define IVP_EVT_EXPIRED     0
`define IVP_EVT_MOVED       1
`define IVP_EVT_WIDTH       2
`define IVP_WDT_FLAG_BIT    0

// ==========================================================================
// Unlock window length in clock cycles
`define IVP_UNLOCK_CYCLES   3'h4
`define IVP_UNLOCK_LAST     3'h1

// ==========================================================================
// Vector numbers, sources and addresses (word addresses)
`define IVP_RESET_ADDR      16'h0000
`define IVP_VEC_FIRST       6'h02
`define IVP_VEC_USB_GEN     6'h0B
`define IVP_VEC_WDT         6'h0D
`define IVP_VEC_LAST        6'h26
`define IVP_VEC_LAST_OFS    16'h004A
`define IVP_VEC_STEP        16'h0002
`define IVP_NUM_SRC         37
`define IVP_SRC_WDT         11
`define IVP_SRC_USB_GEN     10'h200
`define IVP_SRC_LAST        37'h10_0000_0000

// ==========================================================================
// Boot section start per boot size fuse setting (plain defaults)
`define IVP_BOOT_START_SZ0  16'hF000
`define IVP_BOOT_START_SZ1  16'hF800
`define IVP_BOOT_START_SZ2  16'hFC00
`define IVP_BOOT_START_SZ3  16'hFE00

`endif

// [common/ivp_pkg.sv]
/*
 * Types and shared arithmetic of the interrupt vector placement block.
 * Assumes ivp_regs.svh is on the include path.
 */
`include "ivp_regs.svh"

package ivp_pkg;

	// ======================================================================
	// Carriers
	typedef struct packed {
		logic        valid;
		logic [5:0]  num;
		logic [15:0] addr;
	} ivp_vec_type;

	typedef struct packed {
		logic debug_dis;
		logic pullup_dis;
		logic select;
	} ivp_ctl_type;

	// Fuse and lock levels; zero means programmed.
	typedef struct packed {
		logic       boot_reset;
		logic [1:0] boot_size;
		logic       app_lock;
		logic       boot_lock;
	} ivp_fuse_type;

	typedef struct packed {
		logic active;
		logic [2:0] count;
		logic expired;
	} ivp_timer_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic arready;
		logic aw_held;
		logic [2:0] aw_sel;
		logic w_held;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		ivp_ctl_type ctl;
		logic await_instr;
		logic [`IVP_EVT_WIDTH-1:0] evt_status;
		logic [`IVP_EVT_WIDTH-1:0] evt_mask;
		logic irq;
		logic wdt_flag;
		logic blocked;
		ivp_fuse_type fuse_meta;
		ivp_fuse_type fuse_sync;
		logic [15:0] reset_addr;
		logic [15:0] vec_base;
	} ivp_main_type;

	// ======================================================================
	// Start of the boot section for a boot size fuse setting.
	function automatic logic [15:0] ivp_boot_start(input logic [1:0] size);
		case (size)
			2'h0: ivp_boot_start = `IVP_BOOT_START_SZ0;
			2'h1: ivp_boot_start = `IVP_BOOT_START_SZ1;
			2'h2: ivp_boot_start = `IVP_BOOT_START_SZ2;
			default: ivp_boot_start = `IVP_BOOT_START_SZ3;
		endcase
	endfunction : ivp_boot_start

	// Register decode of a bus address.
	function automatic logic [2:0] ivp_decode(input logic [31:0] a);
		case (a)
			`IVP_OFS_CONTROL:    ivp_decode = `IVP_SEL_CONTROL;
			`IVP_OFS_EVT_STATUS: ivp_decode = `IVP_SEL_EVT_STATUS;
			`IVP_OFS_EVT_MASK:   ivp_decode = `IVP_SEL_EVT_MASK;
			`IVP_OFS_STATE:      ivp_decode = `IVP_SEL_STATE;
			`IVP_OFS_WDT_FLAG:   ivp_decode = `IVP_SEL_WDT_FLAG;
			default:             ivp_decode = `IVP_SEL_NONE;
		endcase
	endfunction : ivp_decode

endpackage : ivp_pkg

// [rtl/ivp_unlock_timer.sv]
/*
 * Timed unlock window for the vector table select bit.
 * Assumes start and stop come from logic on aclk.
 */
`timescale 1ns/100ps
`include "ivp_regs.svh"

module ivp_unlock_timer (
	// Clock and reset.
	input  wire logic aclk,
	input  wire logic aresetn,
	// Window control.
	input  wire logic start,
	input  wire logic stop,
	// Window state.
	output      logic active,
	output      logic expired
);

	ivp_pkg::ivp_timer_type st_reg;
	ivp_pkg::ivp_timer_type st_next;

	// ======================================================================
	// Window counter
	// timed self clear.
	always_comb begin
		st_next = st_reg;
		st_next.expired = 1'b0;
		if (start) begin
			st_next.active = 1'b1;
			st_next.count = `IVP_UNLOCK_CYCLES;
		end else if (stop) begin
			st_next.active = 1'b0;
		end else if (st_reg.active) begin
			st_next.count = st_reg.count - 3'h1;
			if (st_reg.count == `IVP_UNLOCK_LAST) begin
				st_next.active = 1'b0;
				st_next.expired = 1'b1;
			end
		end
	end

	// The whole state registers on every edge.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign active  = st_reg.active;
	assign expired = st_reg.expired;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	unlock_len_a:
	assert property (($rose(st_reg.active) ##0 (!stop && !start) [*4])
		|=> (!st_reg.active && st_reg.expired))
		else $error("unlock window not four cycles");

	unlock_cut_a:
	assert property ((st_reg.active && stop && !start) |=> !st_reg.active)
		else $error("unlock not cleared on select write");

endmodule : ivp_unlock_timer

// [rtl/ivp_vec_select.sv]
/*
 * Picks the pending request with the lowest vector number and forms its
 * program address. Assumes all inputs are on aclk.
 */
`timescale 1ns/100ps
`include "ivp_regs.svh"

module ivp_vec_select (
	// Clock and reset.
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// Requests and gating.
	input  wire logic [`IVP_NUM_SRC-1:0] pending,
	input  wire logic                    block,
	input  wire logic [15:0]             base,
	// Selected vector.
	output      ivp_pkg::ivp_vec_type    vec
);

	ivp_pkg::ivp_vec_type st_reg;
	ivp_pkg::ivp_vec_type st_next;

	// Index of the lowest set request bit.
	function automatic logic [5:0] lowest_src(
		input logic [`IVP_NUM_SRC-1:0] req);
		lowest_src = 6'h00;
		for (int i = `IVP_NUM_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				lowest_src = 6'(i);
			end
		end
	endfunction : lowest_src

	// ======================================================================
	// Selection
	// lowest number wins.
	always_comb begin
		st_next.valid = (|pending) && !block;
		st_next.num = lowest_src(pending) + `IVP_VEC_FIRST;
		st_next.addr = base + 16'(({10'h000, st_next.num} - 16'h0001)
			* `IVP_VEC_STEP);
	end

	// The whole state registers on every edge.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign vec = st_reg;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	lowest_first_a:
	assert property ((!block && pending[0])
		|=> (vec.valid && vec.num == `IVP_VEC_FIRST))
		else $error("lowest request not served first");

	first_addr_a:
	assert property ((!block && pending[0])
		|=> vec.addr == 16'($past(base) + `IVP_VEC_STEP))
		else $error("first vector address wrong");

	usb_slot_a:
	assert property ((!block && pending[9:0] == `IVP_SRC_USB_GEN)
		|=> vec.num == `IVP_VEC_USB_GEN)
		else $error("usb general vector wrong");

	last_slot_a:
	assert property ((!block && pending == `IVP_SRC_LAST)
		|=> (vec.num == `IVP_VEC_LAST
		&& vec.addr == 16'($past(base) + `IVP_VEC_LAST_OFS)))
		else $error("last vector wrong");

	vec_gated_a:
	assert property (block |=> !vec.valid)
		else $error("vector offered while blocked");

endmodule : ivp_vec_select

// [rtl/ivp_vector_ctrl.sv]
/*
 * Reset and interrupt vector placement: control register, timed unlock,
 * interrupt blocking, watchdog flag and vector offer to the core.
 * Assumes an AXI4-Lite master on aclk, a core that pulses instr_done per
 * retired instruction and vec_ack when it enters a vector, and fuse
 * levels that arrive from outside the clock domain.
 */
`timescale 1ns/100ps
`include "ivp_regs.svh"

module ivp_vector_ctrl (
	// Clock and reset.
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// AXI4-Lite write channels.
	input  wire logic [31:0]             awaddr,
	input  wire logic                    awvalid,
	output      logic                    awready,
	input  wire logic [31:0]             wdata,
	input  wire logic [3:0]              wstrb,
	input  wire logic                    wvalid,
	output      logic                    wready,
	output      logic [1:0]              bresp,
	output      logic                    bvalid,
	input  wire logic                    bready,
	// AXI4-Lite read channels.
	input  wire logic [31:0]             araddr,
	input  wire logic                    arvalid,
	output      logic                    arready,
	output      logic [31:0]             rdata,
	output      logic [1:0]              rresp,
	output      logic                    rvalid,
	input  wire logic                    rready,
	// Peripheral requests, index 0 is vector 2.
	input  wire logic [`IVP_NUM_SRC-1:0] src_req,
	// Core side.
	input  wire logic                    global_irq_enable,
	input  wire logic                    exec_in_boot,
	input  wire logic                    instr_done,
	input  wire logic                    vec_ack,
	input  wire logic [5:0]              vec_ack_num,
	output      logic                    irq_valid,
	output      logic [5:0]              irq_vector_num,
	output      logic [15:0]             irq_vector_addr,
	output      logic [15:0]             reset_addr,
	output      logic                    intr_blocked,
	// Fuse and lock levels, zero means programmed.
	input  wire logic                    boot_reset_fuse,
	input  wire logic [1:0]              boot_size_fuses,
	input  wire logic                    app_section_lock_bit,
	input  wire logic                    boot_section_lock_bit,
	// Control outputs.
	output      logic                    vector_table_select,
	output      logic                    pullup_disable,
	output      logic                    debug_port_disable,
	output      logic                    irq
);

	// ======================================================================
	// State and internal nets
	ivp_pkg::ivp_main_type            st_reg;
	ivp_pkg::ivp_main_type            st_next;
	ivp_pkg::ivp_vec_type             vec;
	logic                             unlock_active;
	logic                             unlock_expired;
	logic                             start;
	logic                             stop;
	logic                             moved;
	logic                             lock_block;
	logic                             block_now;
	logic [`IVP_NUM_SRC-1:0]          pending;
	logic [2:0]                       rsel;
	logic [7:0]                       ctl_read;

	// ======================================================================
	// Submodules
	ivp_unlock_timer u_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (start),
		.stop    (stop),
		.active  (unlock_active),
		.expired (unlock_expired)
	);

	ivp_vec_select u_select (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pending (pending),
		.block   (block_now),
		.base    (st_reg.vec_base),
		.vec     (vec)
	);

	// ======================================================================
	// Next state of the whole block.
	always_comb begin
		st_next = st_reg;
		start = 1'b0;
		stop = 1'b0;
		moved = 1'b0;
		rsel = `IVP_SEL_NONE;

		// Fuse levels pass two flip-flops before use.
		st_next.fuse_meta = '{boot_reset: boot_reset_fuse,
			boot_size: boot_size_fuses,
			app_lock: app_section_lock_bit,
			boot_lock: boot_section_lock_bit};
		st_next.fuse_sync = st_reg.fuse_meta;

		if (st_reg.await_instr && instr_done) begin
			st_next.await_instr = 1'b0;
		end

		if (vec_ack && vec_ack_num == `IVP_VEC_WDT) begin
			st_next.wdt_flag = 1'b0;
		end

		// Write address and data are taken in either order.
		if (awvalid && st_reg.awready) begin
			st_next.aw_held = 1'b1;
			st_next.aw_sel = ivp_pkg::ivp_decode(awaddr);
		end
		if (wvalid && st_reg.wready) begin
			st_next.w_held = 1'b1;
			st_next.w_data = wdata[7:0];
			st_next.w_lane0 = wstrb[0];
		end

		// A held address and data pair performs the write.
		if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
			st_next.aw_held = 1'b0;
			st_next.w_held = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = (st_reg.aw_sel == `IVP_SEL_NONE) ?
				`IVP_RESP_SLVERR : `IVP_RESP_OKAY;
			if (st_reg.w_lane0) begin
				case (st_reg.aw_sel)
					`IVP_SEL_CONTROL: begin
						st_next.ctl.debug_dis =
							st_reg.w_data[`IVP_CTL_DEBUG_DIS];
						st_next.ctl.pullup_dis =
							st_reg.w_data[`IVP_CTL_PULLUP_DIS];
						if (st_reg.w_data[`IVP_CTL_UNLOCK]) begin
							start = 1'b1;
						end else if (unlock_active) begin
							stop = 1'b1;
							moved = 1'b1;
							st_next.ctl.select =
								st_reg.w_data[`IVP_CTL_SELECT];
							st_next.await_instr = 1'b1;
						end
					end
					`IVP_SEL_EVT_STATUS: begin
						st_next.evt_status = st_next.evt_status
							& ~st_reg.w_data[`IVP_EVT_WIDTH-1:0];
					end
					`IVP_SEL_EVT_MASK: begin
						st_next.evt_mask =
							st_reg.w_data[`IVP_EVT_WIDTH-1:0];
					end
					`IVP_SEL_WDT_FLAG: begin
						if (st_reg.w_data[`IVP_WDT_FLAG_BIT]) begin
							st_next.wdt_flag = 1'b0;
						end
					end
					default: begin
						st_next.bresp = st_next.bresp;
					end
				endcase
			end
		end
		if (st_reg.bvalid && bready) begin
			st_next.bvalid = 1'b0;
		end

		// A watchdog time-out sets its flag; set wins over any clear.
		if (src_req[`IVP_SRC_WDT]) begin
			st_next.wdt_flag = 1'b1;
		end

		// Events are sticky and win over a clear in the same cycle.
		if (unlock_expired) begin
			st_next.evt_status[`IVP_EVT_EXPIRED] = 1'b1;
		end
		if (moved) begin
			st_next.evt_status[`IVP_EVT_MOVED] = 1'b1;
		end
		st_next.irq = |(st_reg.evt_status & st_reg.evt_mask);

		// Read channel answers one cycle after the address is taken.
		if (arvalid && st_reg.arready) begin
			rsel = ivp_pkg::ivp_decode(araddr);
			st_next.rvalid = 1'b1;
			st_next.rresp = `IVP_RESP_OKAY;
			case (rsel)
				`IVP_SEL_CONTROL: begin
					st_next.rdata = {24'h00_0000, ctl_read};
				end
				`IVP_SEL_EVT_STATUS: begin
					st_next.rdata = {30'h0000_0000, st_reg.evt_status};
				end
				`IVP_SEL_EVT_MASK: begin
					st_next.rdata = {30'h0000_0000, st_reg.evt_mask};
				end
				`IVP_SEL_STATE: begin
					st_next.rdata = {st_reg.vec_base, 13'h0000,
						st_reg.await_instr, unlock_active, st_reg.blocked};
				end
				`IVP_SEL_WDT_FLAG: begin
					st_next.rdata = {31'h0000_0000, st_reg.wdt_flag};
				end
				default: begin
					st_next.rdata = 32'h0000_0000;
					st_next.rresp = `IVP_RESP_SLVERR;
				end
			endcase
		end
		if (st_reg.rvalid && rready) begin
			st_next.rvalid = 1'b0;
		end

		// Ready stays low while a request is held or answered.
		st_next.awready = !st_next.aw_held && !st_next.bvalid;
		st_next.wready = !st_next.w_held && !st_next.bvalid;
		st_next.arready = !st_next.rvalid;

		st_next.reset_addr = st_reg.fuse_sync.boot_reset ?
			`IVP_RESET_ADDR :
			ivp_pkg::ivp_boot_start(st_reg.fuse_sync.boot_size);
		st_next.vec_base = st_reg.ctl.select ?
			ivp_pkg::ivp_boot_start(st_reg.fuse_sync.boot_size) :
			`IVP_RESET_ADDR;
		st_next.blocked = block_now;
	end

	// ======================================================================
	// Control read value and interrupt gating
	// reserved bits read zero.
	assign ctl_read = {st_reg.ctl.debug_dis, 2'h0, st_reg.ctl.pullup_dis,
		2'h0, st_reg.ctl.select, unlock_active};

	assign lock_block =
		(st_reg.ctl.select && !st_reg.fuse_sync.app_lock
			&& !exec_in_boot)
		|| (!st_reg.ctl.select && !st_reg.fuse_sync.boot_lock
			&& exec_in_boot);

	assign block_now = start || unlock_active || st_reg.await_instr
		|| lock_block || !global_irq_enable;

	always_comb begin
		pending = src_req;
		pending[`IVP_SRC_WDT] = st_reg.wdt_flag;
	end

	// The whole state registers on every edge.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ======================================================================
	// Outputs, all from flip-flops
	assign awready             = st_reg.awready;
	assign wready              = st_reg.wready;
	assign bvalid              = st_reg.bvalid;
	assign bresp               = st_reg.bresp;
	assign arready             = st_reg.arready;
	assign rvalid              = st_reg.rvalid;
	assign rresp               = st_reg.rresp;
	assign rdata               = st_reg.rdata;
	assign irq_valid           = vec.valid;
	assign irq_vector_num      = vec.num;
	assign irq_vector_addr     = vec.addr;
	assign reset_addr          = st_reg.reset_addr;
	assign intr_blocked        = st_reg.blocked;
	assign vector_table_select = st_reg.ctl.select;
	assign pullup_disable      = st_reg.ctl.pullup_dis;
	assign debug_port_disable  = st_reg.ctl.debug_dis;
	assign irq                 = st_reg.irq;

	// ======================================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sel_guard_a:
	assert property (!$stable(st_reg.ctl.select) |-> $past(unlock_active))
		else $error("select changed without unlock");

	block_unlock_a:
	assert property ((unlock_active || st_reg.await_instr) |=> !irq_valid)
		else $error("interrupts not blocked during unlock");

	lock_app_a:
	assert property ((st_reg.ctl.select && !st_reg.fuse_sync.app_lock
		&& !exec_in_boot) |=> (st_reg.blocked && !irq_valid))
		else $error("app lock did not block");

	lock_boot_a:
	assert property ((!st_reg.ctl.select && !st_reg.fuse_sync.boot_lock
		&& exec_in_boot) |=> st_reg.blocked)
		else $error("boot lock did not block");

	wdt_clear_a:
	assert property ((vec_ack && vec_ack_num == `IVP_VEC_WDT
		&& !src_req[`IVP_SRC_WDT]) |=> !st_reg.wdt_flag)
		else $error("watchdog flag not cleared");

	reset_addr_a:
	assert property (st_reg.fuse_sync.boot_reset |=> ##1
		(reset_addr == `IVP_RESET_ADDR || !$past(st_reg.fuse_sync.boot_reset)))
		else $error("reset address wrong");

	write_resp_a:
	assert property ((st_reg.aw_held && st_reg.w_held && !st_reg.bvalid)
		|=> (bvalid && !awready && !wready))
		else $error("write response late");

	irq_level_a:
	assert property (irq == $past(|(st_reg.evt_status & st_reg.evt_mask)))
		else $error("interrupt output mismatch");

endmodule : ivp_vector_ctrl

// [test/ivp_core_model.sv]
/*
 * Core model: retires instructions and enters offered vectors.
 * Assumes the vector offer of the block on aclk.
 */
`timescale 1ns/100ps

module ivp_core_model (
	// Clock and reset.
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Offer and acknowledge enable.
	input  wire logic       irq_valid,
	input  wire logic [5:0] irq_vector_num,
	input  wire logic       ack_en,
	// Core events.
	output      logic       instr_done,
	output      logic       vec_ack,
	output      logic [5:0] vec_ack_num
);
	logic [1:0] cnt_reg;

	// One instruction retires every fourth cycle; a standing offer is entered every other cycle.
	// vector entry
	always_ff @(posedge aclk) begin
		cnt_reg     <= aresetn ? cnt_reg + 2'h1 : 2'h0;
		instr_done  <= aresetn && (cnt_reg == 2'h3);
		vec_ack     <= aresetn && ack_en && irq_valid && !vec_ack;
		vec_ack_num <= !aresetn ? 6'h00 :
			(irq_valid ? irq_vector_num : ~vec_ack_num);
	end
endmodule : ivp_core_model

// [test/test_interrupt_vector_placement.sv]
/*
 * Self-checking bench of the vector placement block.
 * Assumes the block and the core model; fixed seed random requests.
 */
`timescale 1ns/100ps
`include "ivp_regs.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end

module test_interrupt_vector_placement;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic global_irq_enable, exec_in_boot, ack_en, boot_reset_fuse;
	logic app_section_lock_bit, boot_section_lock_bit;
	logic awready, wready, bvalid, arready, rvalid, irq_valid, irq;
	logic intr_blocked, vector_table_select, pullup_disable;
	logic debug_port_disable, instr_done, vec_ack;
	logic [31:0] awaddr, wdata, araddr, rdata, rd, sv, sw, seed;
	logic [3:0]  wstrb;
	logic [1:0]  boot_size_fuses, bresp, rresp, rr, rb;
	logic [36:0] src_req;
	logic [15:0] bs, irq_vector_addr, reset_addr;
	logic [5:0]  irq_vector_num, vec_ack_num;
	int          err_count, total_checks, cycles;

	ivp_vector_ctrl ivp_vector_ctrl_inst (.aclk, .aresetn, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .src_req, .global_irq_enable, .exec_in_boot,
		.instr_done, .vec_ack, .vec_ack_num, .irq_valid, .irq_vector_num,
		.irq_vector_addr, .reset_addr, .intr_blocked, .boot_reset_fuse,
		.boot_size_fuses, .app_section_lock_bit, .boot_section_lock_bit,
		.vector_table_select, .pullup_disable, .debug_port_disable, .irq);
	ivp_core_model ivp_core_model_inst (.aclk, .aresetn, .irq_valid,
		.irq_vector_num, .ack_en, .instr_done, .vec_ack, .vec_ack_num);

	// ======================================================================
	// Helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Lowest pending vector number of a request set.
	function automatic logic [5:0] lowest(input logic [36:0] r);
		lowest = 6'h00;
		for (int k = 36; k >= 0; k--) if (r[k]) lowest = 6'(k + 2);
	endfunction : lowest

	function automatic logic [15:0] bstart(input logic [1:0] s);
		case (s)
			2'h0: bstart = `IVP_BOOT_START_SZ0;
			2'h1: bstart = `IVP_BOOT_START_SZ1;
			2'h2: bstart = `IVP_BOOT_START_SZ2;
			default: bstart = `IVP_BOOT_START_SZ3;
		endcase
	endfunction : bstart

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc

	// Write: address and data offered together, each released when taken.
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rb = bresp;
	endtask : wr

	task automatic rdr(input logic [31:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rr = rresp;
	endtask : rdr

	task automatic results();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : results

	// Clock of 20 ns and a cycle ceiling against hangs.
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 4000) begin
			err_count++;
			results();
		end
	end

	// ======================================================================
	// Main sequence
	initial begin
		{aresetn, awvalid, wvalid, arvalid, ack_en, exec_in_boot} = '0;
		{bready, rready, global_irq_enable, boot_reset_fuse} = '1;
		{app_section_lock_bit, boot_section_lock_bit} = 2'h3;
		{awaddr, wdata, araddr, src_req, boot_size_fuses} = '0;
		wstrb = 4'hF;
		seed = 32'hDF4E;
		cyc(8);
		aresetn <= 1'b1;
		cyc(5);
		rdr(`IVP_OFS_CONTROL);
		`CHK(rd, 32'h0)
		`CHK(rr, `IVP_RESP_OKAY)
		`CHK(reset_addr, `IVP_RESET_ADDR)
		rdr(32'h40);
		`CHK(rr, `IVP_RESP_SLVERR)
		wr(32'h40, 32'h0);
		`CHK(rb, `IVP_RESP_SLVERR)
		for (int i = 0; i < 37; i++) if (i != 11) begin
			src_req <= 37'h1 << i;
			cyc(3);
			`CHK(irq_vector_num, 6'(i + 2))
			`CHK(irq_vector_addr, 16'(2 * i + 2))
		end
		repeat (20) begin
			sv = xs();
			sw = xs();
			src_req <= ({sv[4:0], sw} & ~(37'h1 << 11)) | (37'h1 << 36);
			cyc(3);
			`CHK(irq_vector_num, lowest(src_req))
		end
		wr(`IVP_OFS_CONTROL, 32'h90);
		`CHK(rb, `IVP_RESP_OKAY)
		rdr(`IVP_OFS_CONTROL);
		`CHK({rd[7:0], pullup_disable, debug_port_disable}, 10'h243)
		wstrb <= 4'h0;
		wr(`IVP_OFS_CONTROL, 32'h00);
		wstrb <= 4'hF;
		`CHK({pullup_disable, debug_port_disable}, 2'h3)
		sv = xs();
		boot_size_fuses <= sv[1:0];
		boot_reset_fuse <= 1'b0;
		bs = bstart(sv[1:0]);
		src_req <= 37'h1;
		cyc(5);
		`CHK(reset_addr, bs)
		wr(`IVP_OFS_CONTROL, 32'h01);
		`CHK({intr_blocked, irq_valid}, 2'h2)
		wr(`IVP_OFS_CONTROL, 32'h02);
		`CHK(vector_table_select, 1'b1)
		rdr(`IVP_OFS_CONTROL);
		`CHK(rd[7:0], 8'h02)
		cyc(8);
		`CHK(irq_vector_addr, bs + 16'h2)
		rdr(`IVP_OFS_STATE);
		`CHK(rd, {bs, 16'h0000})
		app_section_lock_bit <= 1'b0;
		cyc(5);
		`CHK(irq_valid, 1'b0)
		exec_in_boot <= 1'b1;
		cyc(5);
		`CHK(irq_valid, 1'b1)
		global_irq_enable <= 1'b0;
		cyc(3);
		`CHK({intr_blocked, irq_valid}, 2'h2)
		global_irq_enable <= 1'b1;
		app_section_lock_bit <= 1'b1;
		wr(`IVP_OFS_CONTROL, 32'h00);
		`CHK(vector_table_select, 1'b1)
		wr(`IVP_OFS_CONTROL, 32'h01);
		wr(`IVP_OFS_CONTROL, 32'h00);
		boot_section_lock_bit <= 1'b0;
		cyc(8);
		`CHK({vector_table_select, irq_valid}, 2'h0)
		boot_section_lock_bit <= 1'b1;
		wr(`IVP_OFS_EVT_MASK, 32'h01);
		wr(`IVP_OFS_CONTROL, 32'h01);
		cyc(6);
		`CHK({intr_blocked, irq_valid, irq}, 3'h3)
		rdr(`IVP_OFS_CONTROL);
		`CHK(rd[7:0], 8'h00)
		wr(`IVP_OFS_EVT_STATUS, 32'h03);
		cyc(2);
		`CHK(irq, 1'b0)
		src_req <= 37'h1 << 11;
		@(posedge aclk);
		src_req <= 37'h0;
		cyc(3);
		`CHK(irq_vector_addr, 16'h0018)
		ack_en <= 1'b1;
		cyc(4);
		`CHK(irq_valid, 1'b0)
		rdr(`IVP_OFS_WDT_FLAG);
		`CHK(rd[0], 1'b0)
		results();
	end
endmodule : test_interrupt_vector_placement
